// ===== motor_pwm_time_base.sv
`timescale 1ns/1ps
module motor_pwm_time_base (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Processor state
  input wire logic cpuIdle,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  // Events
  output logic periodEvent,
  output logic irq,
  // Six-output pins
  output logic six_out_high_pair1,
  output logic six_out_low_pair1,
  output logic six_out_high_pair2,
  output logic six_out_low_pair2,
  output logic six_out_high_pair3,
  output logic six_out_low_pair3,
  // Two-output pins
  output logic two_out_high,
  output logic two_out_low
);
  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic timebase_enable;
  logic timebase_stop_in_idle;
  logic [3:0] output_postscale_sel;
  logic [1:0] input_prescale_sel;
  pwm_tb_pkg::count_mode_t count_mode_sel;
  logic count_direction_flag;
  logic [14:0] timebase_count_value;
  logic [14:0] timebase_period_value;
  logic [3:0] pair_independent_sel;
  logic [14:0] duty [pwm_tb_pkg::NUM_PAIRS];
  logic [1:0] irqStatus;
  logic [1:0] irqMask;
  logic [3:0] postCnt;
  pwm_tb_pkg::reg_req_t req;
  pwm_tb_pkg::pin_pair_t pins [pwm_tb_pkg::NUM_PAIRS];

  logic run;
  logic tick;
  logic atPeriod;
  logic atZero;
  logic upDown;
  logic wrap;
  logic bottomEvt;
  logic postOut;
  logic wrControl;
  logic wrCount;

  assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};
  assign wrControl = req.wr && (req.addr == pwm_tb_pkg::ADDR_CONTROL);
  assign wrCount = req.wr && (req.addr == pwm_tb_pkg::ADDR_COUNT);

  // ----------------------------------------------------------------------
  // Count clock
  // ----------------------------------------------------------------------
  assign run = timebase_enable
    && !(timebase_stop_in_idle && cpuIdle);

  pwm_prescaler u_pre (
    .mclk(mclk),
    .reset(reset),
    .run(run),
    .sel(input_prescale_sel),
    .tick(tick)
  );

  assign atPeriod = (timebase_count_value >= timebase_period_value);
  assign atZero = (timebase_count_value == 15'h0000);
  assign upDown = (count_mode_sel == pwm_tb_pkg::MODE_UPDOWN)
    || (count_mode_sel == pwm_tb_pkg::MODE_UPDOWN_DBL);
  // Period event: wrap in edge modes, bottom turn in up/down modes
  assign wrap = tick && atPeriod && !upDown;
  assign bottomEvt = tick && upDown && count_direction_flag
    && (timebase_count_value <= 15'h0001);

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      timebase_enable <= pwm_tb_pkg::RESET_CONTROL[pwm_tb_pkg::BIT_ENABLE];
      timebase_stop_in_idle <= 1'b0;
      output_postscale_sel <= 4'h0;
      input_prescale_sel <= 2'h0;
      count_mode_sel <= pwm_tb_pkg::MODE_FREE;
    end else begin
      if (wrControl) begin
        timebase_enable <= req.wdata[pwm_tb_pkg::BIT_ENABLE];
        timebase_stop_in_idle <= req.wdata[pwm_tb_pkg::BIT_STOP_IDLE];
        output_postscale_sel <= req.wdata[pwm_tb_pkg::POST_LSB +: 4];
        input_prescale_sel <= req.wdata[pwm_tb_pkg::PRE_LSB +: 2];
        count_mode_sel <= pwm_tb_pkg::count_mode_t'(
          req.wdata[pwm_tb_pkg::MODE_LSB +: 2]);
      end else if (wrap && count_mode_sel == pwm_tb_pkg::MODE_SINGLE) begin
        timebase_enable <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Counter and direction
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      timebase_count_value <= pwm_tb_pkg::RESET_COUNT;
    end else if (wrCount) begin
      timebase_count_value <= req.wdata[14:0];
    end else if (tick) begin
      if (!upDown) begin
        if (atPeriod) begin
          timebase_count_value <= 15'h0000;
        end else begin
          timebase_count_value <= timebase_count_value + 15'h0001;
        end
      end else if (count_direction_flag) begin
        if (!atZero) begin
          timebase_count_value <= timebase_count_value - 15'h0001;
        end
      end else if (!atPeriod) begin
        timebase_count_value <= timebase_count_value + 15'h0001;
      end else begin
        timebase_count_value <= timebase_count_value - 15'h0001;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      count_direction_flag <= 1'b0;
    end else if (!upDown) begin
      count_direction_flag <= 1'b0;
    end else if (tick) begin
      if (!count_direction_flag && atPeriod) begin
        count_direction_flag <= 1'b1;
      end else if (count_direction_flag && bottomEvt) begin
        count_direction_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Postscaler
  // ----------------------------------------------------------------------
  logic baseEvt;
  logic topEvt;

  assign topEvt = tick && upDown && !count_direction_flag && atPeriod;
  assign baseEvt = wrap || bottomEvt;
  assign postOut = baseEvt && (postCnt >= output_postscale_sel);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      postCnt <= 4'h0;
    end else if (wrControl) begin
      postCnt <= 4'h0;
    end else if (baseEvt) begin
      if (postCnt >= output_postscale_sel) begin
        postCnt <= 4'h0;
      end else begin
        postCnt <= postCnt + 4'h1;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      periodEvent <= 1'b0;
    end else begin
      periodEvent <= postOut;
    end
  end

  // ----------------------------------------------------------------------
  // Period, pair mode and duty registers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      timebase_period_value <= pwm_tb_pkg::RESET_PERIOD;
      pair_independent_sel <= pwm_tb_pkg::RESET_PAIRMODE;
      for (int i = 0; i < pwm_tb_pkg::NUM_PAIRS; i++) begin
        duty[i] <= pwm_tb_pkg::RESET_DUTY;
      end
    end else if (req.wr) begin
      unique case (req.addr)
        pwm_tb_pkg::ADDR_PERIOD: timebase_period_value <= req.wdata[14:0];
        pwm_tb_pkg::ADDR_PAIRMODE: pair_independent_sel <= req.wdata[3:0];
        pwm_tb_pkg::ADDR_DUTY1: duty[0] <= req.wdata[14:0];
        pwm_tb_pkg::ADDR_DUTY2: duty[1] <= req.wdata[14:0];
        pwm_tb_pkg::ADDR_DUTY3: duty[2] <= req.wdata[14:0];
        pwm_tb_pkg::ADDR_DUTY4: duty[3] <= req.wdata[14:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------
  logic [1:0] irqSet;
  logic [1:0] irqClr;

  assign irqSet[pwm_tb_pkg::IRQ_PERIOD] = postOut;
  assign irqSet[pwm_tb_pkg::IRQ_BOTTOM] = topEvt
    && (count_mode_sel == pwm_tb_pkg::MODE_UPDOWN_DBL);
  assign irqClr = (req.wr && req.addr == pwm_tb_pkg::ADDR_IRQ_STATUS)
    ? req.wdata[1:0] : 2'h0;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      irqStatus <= pwm_tb_pkg::RESET_IRQ;
    end else begin
      irqStatus <= (irqStatus & ~irqClr) | irqSet;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      irqMask <= pwm_tb_pkg::RESET_IRQ;
    end else if (req.wr && req.addr == pwm_tb_pkg::ADDR_IRQ_MASK) begin
      irqMask <= req.wdata[1:0];
    end
  end

  assign irq = |(irqStatus & irqMask);

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      regRdata <= 16'h0000;
    end else if (req.rd) begin
      unique case (req.addr)
        pwm_tb_pkg::ADDR_CONTROL: regRdata <= {timebase_enable, 1'b0,
          timebase_stop_in_idle, 5'h00, output_postscale_sel,
          input_prescale_sel, count_mode_sel};
        pwm_tb_pkg::ADDR_COUNT: regRdata <= {count_direction_flag,
          timebase_count_value};
        pwm_tb_pkg::ADDR_PERIOD: regRdata <= {1'b0,
          timebase_period_value};
        pwm_tb_pkg::ADDR_PAIRMODE: regRdata <= {12'h000,
          pair_independent_sel};
        pwm_tb_pkg::ADDR_DUTY1: regRdata <= {1'b0, duty[0]};
        pwm_tb_pkg::ADDR_DUTY2: regRdata <= {1'b0, duty[1]};
        pwm_tb_pkg::ADDR_DUTY3: regRdata <= {1'b0, duty[2]};
        pwm_tb_pkg::ADDR_DUTY4: regRdata <= {1'b0, duty[3]};
        pwm_tb_pkg::ADDR_IRQ_STATUS: regRdata <= {14'h0000, irqStatus};
        pwm_tb_pkg::ADDR_IRQ_MASK: regRdata <= {14'h0000, irqMask};
        default: regRdata <= 16'h0000;
      endcase
    end else begin
      regRdata <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------------
  // Output pairs: three for the six-output group, one for the two-output
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < pwm_tb_pkg::NUM_PAIRS; g++) begin : gPair
    pwm_pair_gen u_pair (
      .mclk(mclk),
      .reset(reset),
      .count(timebase_count_value),
      .duty(duty[g]),
      .independent(pair_independent_sel[g]),
      .pins(pins[g])
    );
  end

  assign six_out_high_pair1 = pins[0].high;
  assign six_out_low_pair1 = pins[0].low;
  assign six_out_high_pair2 = pins[1].high;
  assign six_out_low_pair2 = pins[1].low;
  assign six_out_high_pair3 = pins[2].high;
  assign six_out_low_pair3 = pins[2].low;
  assign two_out_high = pins[3].high;
  assign two_out_low = pins[3].low;
endmodule // motor_pwm_time_base

// ===== pwm_tb_pkg.sv
// Functional notes
// - Counter runs only while timebase_enable (control bit 15) is set.
// - With stop-in-idle set the time base halts during processor Idle.
// - Postscale field divides period events by field value plus one.
// - Prescale field gives count clock of 1, 4, 16 or 64 cycles.
// - Mode 00 runs the time base free-running.
// - Mode 01 is single pulse: one period per start.
// - Mode 10 counts continuously up then down, center aligned.
// - Mode 11 up/down with events at both turning points.
// - Count register bit 15 is read-only direction, 1 when counting down.
// - Count register low fifteen bits hold the count, read and write.
// - Period register holds fifteen-bit period; top bit reads zero.
// - Six-output variant has three generators, each driving a pin pair.
// - Complementary pair drives low output as inverse of high output.
// - Two-output variant has one generator driving one pin pair.
// - Each pair selects independent or complementary by its own bit.
package pwm_tb_pkg;
  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_COUNT = 4'h1;
  localparam logic [3:0] ADDR_PERIOD = 4'h2;
  localparam logic [3:0] ADDR_PAIRMODE = 4'h3;
  localparam logic [3:0] ADDR_DUTY1 = 4'h4;
  localparam logic [3:0] ADDR_DUTY2 = 4'h5;
  localparam logic [3:0] ADDR_DUTY3 = 4'h6;
  localparam logic [3:0] ADDR_DUTY4 = 4'h7;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h9;
  localparam int BIT_ENABLE = 15;
  localparam int BIT_STOP_IDLE = 13;
  localparam int BIT_DIR = 15;
  localparam int POST_LSB = 4;
  localparam int PRE_LSB = 2;
  localparam int MODE_LSB = 0;
  localparam logic [15:0] RESET_CONTROL = 16'h0000;
  localparam logic [14:0] RESET_COUNT = 15'h0000;
  localparam logic [14:0] RESET_PERIOD = 15'h0000;
  localparam logic [3:0] RESET_PAIRMODE = 4'h0;
  localparam logic [14:0] RESET_DUTY = 15'h0000;
  localparam logic [1:0] RESET_IRQ = 2'h0;
  localparam int NUM_PAIRS = 4;
  // Interrupt bits: period event, turning point at period (double update)
  localparam int IRQ_PERIOD = 0;
  localparam int IRQ_BOTTOM = 1;
  // Prescale divide ratios minus one
  localparam logic [5:0] PRE_DIV1 = 6'h00;
  localparam logic [5:0] PRE_DIV4 = 6'h03;
  localparam logic [5:0] PRE_DIV16 = 6'h0f;
  localparam logic [5:0] PRE_DIV64 = 6'h3f;

  typedef enum logic [1:0] {
    MODE_FREE = 2'h0,
    MODE_SINGLE = 2'h1,
    MODE_UPDOWN = 2'h2,
    MODE_UPDOWN_DBL = 2'h3
  } count_mode_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic high;
    logic low;
  } pin_pair_t;
endpackage

// ===== pwm_prescaler.sv
`timescale 1ns/1ps
module pwm_prescaler (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Control
  input wire logic run,
  input wire logic [1:0] sel,
  // Count clock enable
  output logic tick
);
  logic [5:0] cnt;
  logic [5:0] limit;

  always_comb begin
    unique case (sel)
      2'h0: limit = pwm_tb_pkg::PRE_DIV1;
      2'h1: limit = pwm_tb_pkg::PRE_DIV4;
      2'h2: limit = pwm_tb_pkg::PRE_DIV16;
      2'h3: limit = pwm_tb_pkg::PRE_DIV64;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cnt <= 6'h00;
    end else if (!run) begin
      cnt <= 6'h00;
    end else if (cnt >= limit) begin
      cnt <= 6'h00;
    end else begin
      cnt <= cnt + 6'h01;
    end
  end

  assign tick = run && (cnt >= limit);
endmodule // pwm_prescaler

// ===== pwm_pair_gen.sv
`timescale 1ns/1ps
module pwm_pair_gen (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Time base
  input wire logic [14:0] count,
  input wire logic [14:0] duty,
  input wire logic independent,
  // Pins
  output pwm_tb_pkg::pin_pair_t pins
);
  logic active;

  assign active = (count < duty);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pins <= '0;
    end else begin
      pins.high <= active;
      if (independent) begin
        pins.low <= active;
      end else begin
        pins.low <= !active;
      end
    end
  end
endmodule // pwm_pair_gen

// ===== pwm_time_base_checker.sv
`timescale 1ns/1ps
module pwm_time_base_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Bus and processor state
  input wire logic cpuIdle,
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [15:0] regRdata,
  // Events and pins
  input wire logic periodEvent,
  input wire logic irq,
  input wire logic six_out_high_pair1,
  input wire logic six_out_low_pair1,
  input wire logic six_out_high_pair2,
  input wire logic six_out_low_pair2,
  input wire logic six_out_high_pair3,
  input wire logic six_out_low_pair3,
  input wire logic two_out_high,
  input wire logic two_out_low
);
  // ----------------------------------------------------------------------
  // Shadows of written registers
  // ----------------------------------------------------------------------
  logic [3:0] pairMode;
  logic [1:0] pmAge;
  logic [1:0] irqMask;
  logic runEn;
  logic stopIdle;
  logic [1:0] haltAge;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pairMode <= 4'h0;
      pmAge <= 2'h0;
    end else if (regWr && regAddr == pwm_tb_pkg::ADDR_PAIRMODE) begin
      pairMode <= regWdata[3:0];
      pmAge <= 2'h0;
    end else if (pmAge != 2'h2) begin
      pmAge <= pmAge + 2'h1;
    end
  end
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      runEn <= 1'b0;
      stopIdle <= 1'b0;
      irqMask <= 2'h0;
    end else if (regWr && regAddr == pwm_tb_pkg::ADDR_CONTROL) begin
      runEn <= regWdata[pwm_tb_pkg::BIT_ENABLE];
      stopIdle <= regWdata[pwm_tb_pkg::BIT_STOP_IDLE];
    end else if (regWr && regAddr == pwm_tb_pkg::ADDR_IRQ_MASK) begin
      irqMask <= regWdata[1:0];
    end
  end
  // Cycles the time base has been held off
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      haltAge <= 2'h0;
    end else if (runEn && !(stopIdle && cpuIdle)) begin
      haltAge <= 2'h0;
    end else if (haltAge != 2'h3) begin
      haltAge <= haltAge + 2'h1;
    end
  end
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  period_top_a: assert property (
    regRd && regAddr == pwm_tb_pkg::ADDR_PERIOD |=> !regRdata[15])
    else $error("period top bit reads one");
  pair1_comp_a: assert property (
    pmAge == 2'h2 && !pairMode[0] |-> six_out_low_pair1 == !six_out_high_pair1)
    else $error("pair 1 low is not inverse of high");
  pair2_comp_a: assert property (
    pmAge == 2'h2 && !pairMode[1] |-> six_out_low_pair2 ^ six_out_high_pair2)
    else $error("pair 2 low is not inverse of high");
  pair3_comp_a: assert property (
    pmAge == 2'h2 && !pairMode[2] |-> six_out_low_pair3 != six_out_high_pair3)
    else $error("pair 3 low is not inverse of high");
  two_comp_a: assert property (
    pmAge == 2'h2 && !pairMode[3] |-> two_out_low == !two_out_high)
    else $error("two-output low is not inverse of high");
  pair_indep_a: assert property (
    pmAge == 2'h2 && pairMode[0] |-> six_out_low_pair1 == six_out_high_pair1)
    else $error("independent pair 1 low differs from high");
  irq_masked_a: assert property (irqMask == 2'h0 |-> !irq)
    else $error("interrupt raised while fully masked");
  halt_quiet_a: assert property (haltAge == 2'h3 |-> !periodEvent)
    else $error("period event while time base held off");
  cover property (periodEvent);
  cover property (irq);
  cover property (pmAge == 2'h2 && pairMode[0]);
endmodule // pwm_time_base_checker

// ===== gate_driver_model.sv
`timescale 1ns/1ps
module gate_driver_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Gate commands
  input wire pwm_tb_pkg::pin_pair_t gate,
  // Fault report
  output logic shootThrough
);
  // Both switches of one leg on at once shorts the supply
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      shootThrough <= 1'b0;
    end else if (gate.high && gate.low) begin
      shootThrough <= 1'b1;
    end
  end
endmodule // gate_driver_model

// ===== motor_pwm_time_base_tb.sv
`timescale 1ns/1ps
module motor_pwm_time_base_tb;
  // ----------------------------------------------------------------------
  // Signals and tasks
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic wrOn;
    logic [3:0] addr;
    logic [15:0] wdata;
    logic [15:0] rexp;
  } row_t;
  row_t rows [0:8] = '{
    '{1'b0, 4'h0, 16'h0000, 16'h0000}, '{1'b0, 4'h1, 16'h0000, 16'h0000},
    '{1'b0, 4'h2, 16'h0000, 16'h0000}, '{1'b1, 4'h2, 16'h8005, 16'h0005},
    '{1'b1, 4'h1, 16'h8003, 16'h0003}, '{1'b1, 4'h0, 16'h20f6, 16'h20f6},
    '{1'b1, 4'h3, 16'h000a, 16'h000a}, '{1'b1, 4'h9, 16'h0003, 16'h0003},
    '{1'b1, 4'hf, 16'hffff, 16'h0000}};
  logic [3:0] postTab [0:2] = '{4'h0, 4'h2, 4'hf};
  logic mclk, reset, cpuIdle, regWr, regRd, periodEvent, irq;
  logic [3:0] regAddr;
  logic [15:0] regWdata, regRdata, gap, hits, top;
  logic high1, low1, high2, low2, high3, low3, highTwo, lowTwo;
  logic shoot1, shootTwo, up, dirs;
  logic [15:0] vals [0:128];
  int failures = 0;
  int checks = 0;

  motor_pwm_time_base i_dut (.mclk(mclk), .reset(reset), .cpuIdle(cpuIdle),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .periodEvent(periodEvent), .irq(irq),
    .six_out_high_pair1(high1), .six_out_low_pair1(low1),
    .six_out_high_pair2(high2), .six_out_low_pair2(low2),
    .six_out_high_pair3(high3), .six_out_low_pair3(low3),
    .two_out_high(highTwo), .two_out_low(lowTwo));
  gate_driver_model i_drv1 (.mclk(mclk), .reset(reset), .gate({high1, low1}),
    .shootThrough(shoot1));
  gate_driver_model i_drvTwo (.mclk(mclk), .reset(reset),
    .gate({highTwo, lowTwo}), .shootThrough(shootTwo));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  // Back-to-back reads, one answer a cycle
  task automatic rdn(input logic [3:0] a, input int n);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      if (i == n - 1) regRd <= 1'b0;
      @(negedge mclk);
      vals[i] = regRdata;
    end
  endtask
  task automatic waitEvent(output logic [15:0] n);
    n = 16'h0000;
    do begin
      @(negedge mclk);
      n = n + 16'h0001;
    end while (periodEvent !== 1'b1 && n < 16'h00c8);
  endtask
  function automatic logic [15:0] ctl(input logic [3:0] post,
                                      input logic [1:0] pre, input logic [1:0] mode);
    return {1'b1, 7'h00, post, pre, mode};
  endfunction
  task automatic print_verdict();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    print_verdict();
  end
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {reset, cpuIdle, regWr, regRd, regAddr, regWdata} = {1'b1, 23'h0};
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].wrOn) wr(rows[i].addr, rows[i].wdata);
      rdn(rows[i].addr, 1);
      check(vals[0], rows[i].rexp);
    end
    wr(pwm_tb_pkg::ADDR_CONTROL, 16'h0000);
    wr(pwm_tb_pkg::ADDR_PERIOD, 16'h7fff);
    for (int p = 0; p < 4; p++) begin
      wr(pwm_tb_pkg::ADDR_COUNT, 16'h0000);
      wr(pwm_tb_pkg::ADDR_CONTROL, ctl(4'h0, 2'(p), 2'h0));
      rdn(pwm_tb_pkg::ADDR_COUNT, 129);
      check(vals[128] - vals[0], 16'h0080 >> (2 * p));
      wr(pwm_tb_pkg::ADDR_CONTROL, 16'h0000);
      rdn(pwm_tb_pkg::ADDR_COUNT, 9);
      check(vals[8], vals[0]);
    end
    wr(pwm_tb_pkg::ADDR_PERIOD, 16'h0004);
    for (int d = 0; d < 4; d++) wr(4'(pwm_tb_pkg::ADDR_DUTY1 + d), 16'h0002);
    wr(pwm_tb_pkg::ADDR_PAIRMODE, 16'h0000);
    wr(pwm_tb_pkg::ADDR_CONTROL, ctl(4'h0, 2'h0, pwm_tb_pkg::MODE_FREE));
    rdn(pwm_tb_pkg::ADDR_COUNT, 12);
    for (int i = 0; i < 11; i++)
      check(vals[i + 1], vals[i] == 16'h0004 ? 16'h0000 : vals[i] + 16'h0001);
    hits = 16'h0000;
    repeat (5) begin
      @(negedge mclk);
      hits = hits + high1 + high2 + high3 + highTwo;
    end
    check(hits, 16'h0008);
    check({shoot1, shootTwo}, 16'h0000);
    wr(pwm_tb_pkg::ADDR_PAIRMODE, 16'h000f);
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    check({shoot1, shootTwo}, 16'h0003);
    foreach (postTab[k]) begin
      wr(pwm_tb_pkg::ADDR_CONTROL, ctl(postTab[k], 2'h0, pwm_tb_pkg::MODE_FREE));
      waitEvent(gap);
      waitEvent(gap);
      check(gap, {12'h000, postTab[k]} * 16'h0005 + 16'h0005);
    end
    wr(pwm_tb_pkg::ADDR_CONTROL, 16'h0000);
    wr(pwm_tb_pkg::ADDR_PERIOD, 16'h0003);
    wr(pwm_tb_pkg::ADDR_COUNT, 16'h0000);
    wr(pwm_tb_pkg::ADDR_IRQ_STATUS, 16'h0003);
    wr(pwm_tb_pkg::ADDR_IRQ_MASK, 16'h0002);
    wr(pwm_tb_pkg::ADDR_CONTROL, ctl(4'h0, 2'h0, pwm_tb_pkg::MODE_UPDOWN));
    rdn(pwm_tb_pkg::ADDR_COUNT, 16);
    {top, dirs} = 17'h0;
    for (int i = 0; i < 15; i++) begin
      up = vals[i + 1][14:0] > vals[i][14:0];
      check(up ? {1'b0, vals[i + 1][14:0] - vals[i][14:0]}
        : {1'b0, vals[i][14:0] - vals[i + 1][14:0]}, 16'h0001);
      if (up) check(vals[i][15], 16'h0000);
      dirs = dirs | vals[i][15];
      if (vals[i][14:0] > top) top = {1'b0, vals[i][14:0]};
    end
    check(top, 16'h0003);
    check(dirs, 16'h0001);
    rdn(pwm_tb_pkg::ADDR_IRQ_STATUS, 1);
    check(vals[0][1], 16'h0000);
    wr(pwm_tb_pkg::ADDR_CONTROL, ctl(4'h0, 2'h0, pwm_tb_pkg::MODE_UPDOWN_DBL));
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    check(irq, 16'h0001);
    wr(pwm_tb_pkg::ADDR_CONTROL, 16'h0000);
    wr(pwm_tb_pkg::ADDR_IRQ_STATUS, 16'h0003);
    @(negedge mclk);
    check(irq, 16'h0000);
    wr(pwm_tb_pkg::ADDR_COUNT, 16'h0000);
    wr(pwm_tb_pkg::ADDR_CONTROL, ctl(4'h0, 2'h0, pwm_tb_pkg::MODE_SINGLE));
    repeat (20) @(posedge mclk);
    rdn(pwm_tb_pkg::ADDR_CONTROL, 1);
    check(vals[0][15], 16'h0000);
    rdn(pwm_tb_pkg::ADDR_COUNT, 4);
    check(vals[3], vals[0]);
    wr(pwm_tb_pkg::ADDR_PERIOD, 16'h7fff);
    cpuIdle <= 1'b1;
    wr(pwm_tb_pkg::ADDR_CONTROL, ctl(4'h0, 2'h0, 2'h0) | 16'h2000);
    rdn(pwm_tb_pkg::ADDR_COUNT, 9);
    check(vals[8], vals[0]);
    wr(pwm_tb_pkg::ADDR_CONTROL, ctl(4'h0, 2'h0, 2'h0));
    rdn(pwm_tb_pkg::ADDR_COUNT, 9);
    check(vals[8] - vals[0], 16'h0008);
    // Mid-run reset: registers and pins return to their idle state
    @(posedge mclk);
    cpuIdle <= 1'b0;
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    rdn(pwm_tb_pkg::ADDR_CONTROL, 1);
    check(vals[0], pwm_tb_pkg::RESET_CONTROL);
    rdn(pwm_tb_pkg::ADDR_COUNT, 1);
    check(vals[0], 16'h0000);
    check({high1, low1, highTwo, lowTwo}, 16'h0005);
    check({irq, periodEvent, shoot1, shootTwo}, 16'h0000);
    print_verdict();
  end
endmodule // motor_pwm_time_base_tb

bind motor_pwm_time_base pwm_time_base_checker i_chk (.mclk(mclk),
  .reset(reset), .cpuIdle(cpuIdle), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .periodEvent(periodEvent), .irq(irq),
  .six_out_high_pair1(six_out_high_pair1), .six_out_low_pair1(six_out_low_pair1),
  .six_out_high_pair2(six_out_high_pair2), .six_out_low_pair2(six_out_low_pair2),
  .six_out_high_pair3(six_out_high_pair3), .six_out_low_pair3(six_out_low_pair3),
  .two_out_high(two_out_high), .two_out_low(two_out_low));
